// ===== sls_pkg.sv
// Shared constants, register map and carrier types for the simplex link status block.
package sls_pkg;

   localparam int LANES_DEF     = 4;
   localparam int DATA_W_DEF    = 32;
   localparam int LOCK_CYC_DEF  = 4;
   localparam int TIMER_CYC_DEF = 64;
   localparam int MIN_RESET_CYC = 6;

   localparam logic [11:0] CTRL_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [11:0] ECNT_OFS = 12'h008;

   localparam int CTRL_TIMER_BIT = 0;
   localparam int CTRL_TXRST_BIT = 1;
   localparam int CTRL_RXRST_BIT = 2;
   localparam logic CTRL_TIMER_RST = 1'b0;

   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
   localparam logic [15:0] CNT_ZERO = 16'h0000;

   typedef struct packed {
      logic restart;
      logic verified;
      logic bonded;
      logic aligned;
   } sls_partner_t;

   localparam sls_partner_t PARTNER_RST = 4'h0;

   typedef enum logic [4:0] {
      st_lane   = 5'b00001,
      st_align  = 5'b00010,
      st_bond   = 5'b00100,
      st_verify = 5'b01000,
      st_up     = 5'b10000
   } sls_state_t;

endpackage

// ===== sls_lane_init.sv
// Per-lane initialisation tracker: lane is up after a run of good sync cycles.
`timescale 1ns/100ps
module sls_lane_init #(
   parameter int LOCK_CYC = sls_pkg::LOCK_CYC_DEF
) (
   input  wire logic clock,
   input  wire logic reset_n,
   input  wire logic ce,
   input  wire logic clear,
   input  wire logic sync,
   output logic      lane_up
);

   logic [7:0] run_ff;
   logic       up_ff;
   wire  logic run_done = (run_ff >= 8'(LOCK_CYC - 1));

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         run_ff <= 8'h00;
         up_ff  <= 1'b0;
      end else if (ce) begin
         if (clear || !sync) begin
            run_ff <= 8'h00;
            up_ff  <= 1'b0;
         end else begin
            run_ff <= run_done ? run_ff : run_ff + 8'h01;
            up_ff  <= run_done;
         end
      end
   end

   assign lane_up = up_ff;

endmodule

// ===== sls_status_top.sv
// Simplex transmit and receive initialisation status cores with an APB control slave.
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/100ps
module sls_status_top #(
   parameter int LANES     = sls_pkg::LANES_DEF,
   parameter int DATA_W    = sls_pkg::DATA_W_DEF,
   parameter int LOCK_CYC  = sls_pkg::LOCK_CYC_DEF,
   parameter int TIMER_CYC = sls_pkg::TIMER_CYC_DEF
) (
   input  wire logic                 clock,
   input  wire logic                 reset_n,
   input  wire logic                 ce,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 tx_system_reset,
   input  wire sls_pkg::sls_partner_t tx_partner,
   input  wire logic [LANES-1:0]     tx_lane_ok,
   input  wire logic                 tx_hard_det,
   input  wire logic                 tx_power_down,
   output logic                      tx_gt_power_down,
   output logic                      tx_channel_up,
   output logic      [LANES-1:0]     tx_lane_up,
   output logic                      tx_hard_err,
   input  wire logic                 rx_system_reset,
   input  wire logic [LANES-1:0]     rx_lane_sync,
   input  wire logic                 rx_bond_done,
   input  wire logic                 rx_verify_done,
   input  wire logic                 rx_frame_det,
   input  wire logic                 rx_soft_det,
   input  wire logic                 rx_hard_det,
   input  wire logic                 rx_power_down,
   input  wire logic                 rx_data_valid_in,
   input  wire logic [DATA_W-1:0]    rx_data_in,
   output logic                      rx_gt_power_down,
   output sls_pkg::sls_partner_t     rx_partner,
   output logic                      rx_channel_up,
   output logic      [LANES-1:0]     rx_lane_up,
   output logic                      rx_hard_err,
   output logic                      frame_err,
   output logic                      soft_err,
   output logic                      rx_data_valid,
   output logic      [DATA_W-1:0]    rx_data
);

   function automatic logic all_lanes(input logic [LANES-1:0] v);
      return &v;
   endfunction

   // Register state.
   logic                  ctrl_timer_ff;
   logic                  tx_srst_ff;
   logic                  rx_srst_ff;
   logic [15:0]           soft_cnt_ff;
   logic [15:0]           frame_cnt_ff;
   logic [31:0]           prdata_ff;
   logic                  pready_ff;
   logic                  pslverr_ff;

   // Core state.
   sls_pkg::sls_state_t   tx_state_ff;
   sls_pkg::sls_state_t   nxt_tx_state;
   sls_pkg::sls_state_t   rx_state_ff;
   sls_pkg::sls_state_t   nxt_rx_state;
   logic [15:0]           tmr_ff;
   logic                  tx_up_ff;
   logic                  tx_hard_ff;
   logic                  rx_up_ff;
   logic                  rx_hard_ff;
   sls_pkg::sls_partner_t rx_partner_ff;
   logic                  frame_q_ff;
   logic                  soft_q_ff;
   logic                  frame_err_ff;
   logic                  soft_err_ff;
   logic                  rx_valid_ff;
   logic [DATA_W-1:0]     rx_data_ff;
   logic                  tx_pd_ff;
   logic                  rx_pd_ff;

   // APB decode.
   wire logic apb_acc  = psel & penable;
   wire logic apb_load = apb_acc & ~pready_ff;
   wire logic apb_done = apb_acc & pready_ff;
   wire logic wr_en    = apb_done & pwrite;
   wire logic hit_ctrl = (paddr == sls_pkg::CTRL_OFS);
   wire logic hit_stat = (paddr == sls_pkg::STAT_OFS);
   wire logic hit_ecnt = (paddr == sls_pkg::ECNT_OFS);
   wire logic map_hit  = hit_ctrl | hit_stat | hit_ecnt;
   wire logic ecnt_clr = wr_en & hit_ecnt;

   wire logic [7:0]  tx_lane8  = 8'(tx_lane_up);
   wire logic [7:0]  rx_lane8  = 8'(rx_lane_up);
   wire logic [31:0] ctrl_word = {31'h0000_0000, ctrl_timer_ff};
   wire logic [31:0] stat_word = {8'h00, rx_lane8, tx_lane8, 1'b0, tx_partner.verified,
                                  tx_partner.bonded, tx_partner.aligned, rx_hard_ff,
                                  rx_up_ff, tx_hard_ff, tx_up_ff};
   wire logic [31:0] ecnt_word = {frame_cnt_ff, soft_cnt_ff};
   wire logic [31:0] rd_word   = hit_ctrl ? ctrl_word :
                                 hit_stat ? stat_word :
                                 hit_ecnt ? ecnt_word : sls_pkg::RD_ZERO;

   // Core resets: system reset or a software reset pulse.
   wire logic tx_core_rst = tx_system_reset | tx_srst_ff;
   wire logic rx_core_rst = rx_system_reset | rx_srst_ff;
   wire logic tx_restart  = tx_core_rst | tx_partner.restart;
   wire logic tx_all_up   = all_lanes(tx_lane_up);
   wire logic rx_all_up   = all_lanes(rx_lane_up);
   wire logic tx_lost     = ~tx_all_up | tx_hard_ff;
   wire logic rx_lost     = ~rx_all_up | rx_hard_ff;
   wire logic tmr_done    = (tmr_ff >= 16'(TIMER_CYC - 1));

   // partner aligned, bonded or verified flag, or timer when the partner is timer based
   wire logic tx_go_align  = ctrl_timer_ff ? tmr_done : tx_partner.aligned;
   wire logic tx_go_bond   = ctrl_timer_ff ? tmr_done : tx_partner.bonded;
   wire logic tx_go_verify = ctrl_timer_ff ? tmr_done : tx_partner.verified;
   wire sls_pkg::sls_state_t after_align = (LANES > 1) ? sls_pkg::st_bond : sls_pkg::st_verify;

   // Lane trackers for both cores.
   genvar gi;
   generate
      for (gi = 0; gi < LANES; gi++) begin : g_lane
         sls_lane_init #(.LOCK_CYC(LOCK_CYC)) u_tx_lane (
            .clock   (clock),
            .reset_n (reset_n),
            .ce      (ce),
            .clear   (tx_restart | tx_hard_ff),
            .sync    (tx_lane_ok[gi]),
            .lane_up (tx_lane_up[gi])
         );
         sls_lane_init #(.LOCK_CYC(LOCK_CYC)) u_rx_lane (
            .clock   (clock),
            .reset_n (reset_n),
            .ce      (ce),
            .clear   (rx_core_rst | rx_hard_ff),
            .sync    (rx_lane_sync[gi]),
            .lane_up (rx_lane_up[gi])
         );
      end
   endgenerate

   always_comb begin
      nxt_tx_state = tx_state_ff;
      case (tx_state_ff)
         sls_pkg::st_lane:   if (tx_all_up && !tx_hard_ff) nxt_tx_state = sls_pkg::st_align;
         sls_pkg::st_align:  if (tx_go_align) nxt_tx_state = after_align;
         sls_pkg::st_bond:   if (tx_go_bond) nxt_tx_state = sls_pkg::st_verify;
         sls_pkg::st_verify: if (tx_go_verify) nxt_tx_state = sls_pkg::st_up;
         sls_pkg::st_up:     nxt_tx_state = sls_pkg::st_up;
         default:            nxt_tx_state = sls_pkg::st_lane;
      endcase
      if (tx_restart || tx_lost) begin
         nxt_tx_state = sls_pkg::st_lane;
      end
   end

   always_comb begin
      nxt_rx_state = rx_state_ff;
      case (rx_state_ff)
         sls_pkg::st_lane:   if (rx_all_up && !rx_hard_ff) nxt_rx_state = sls_pkg::st_align;
         sls_pkg::st_align:  nxt_rx_state = after_align;
         sls_pkg::st_bond:   if (rx_bond_done) nxt_rx_state = sls_pkg::st_verify;
         sls_pkg::st_verify: if (rx_verify_done) nxt_rx_state = sls_pkg::st_up;
         sls_pkg::st_up:     nxt_rx_state = sls_pkg::st_up;
         default:            nxt_rx_state = sls_pkg::st_lane;
      endcase
      if (rx_core_rst || rx_lost) begin
         nxt_rx_state = sls_pkg::st_lane;
      end
   end

   // restart on loss after lanes were up
   wire logic rx_need_restart = rx_lost & (rx_state_ff != sls_pkg::st_lane);
   wire logic frame_evt = rx_frame_det & ~frame_q_ff;
   wire logic soft_evt  = rx_soft_det & ~soft_q_ff;

   // APB slave: one wait state, then the answer.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= sls_pkg::RD_ZERO;
      end else if (ce) begin
         pready_ff  <= apb_load;
         pslverr_ff <= apb_load & ~map_hit;
         prdata_ff  <= (apb_load && !pwrite) ? rd_word : sls_pkg::RD_ZERO;
      end
   end

   // Soft resets are single-cycle pulses so they cannot be left stuck on.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_timer_ff <= sls_pkg::CTRL_TIMER_RST;
         tx_srst_ff    <= 1'b0;
         rx_srst_ff    <= 1'b0;
      end else if (ce) begin
         if (wr_en && hit_ctrl) begin
            ctrl_timer_ff <= pwdata[sls_pkg::CTRL_TIMER_BIT];
         end
         tx_srst_ff <= wr_en & hit_ctrl & pwdata[sls_pkg::CTRL_TXRST_BIT];
         rx_srst_ff <= wr_en & hit_ctrl & pwdata[sls_pkg::CTRL_RXRST_BIT];
      end
   end

   // An event in the clearing cycle is counted, not lost.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         soft_cnt_ff  <= sls_pkg::CNT_ZERO;
         frame_cnt_ff <= sls_pkg::CNT_ZERO;
      end else if (ce) begin
         soft_cnt_ff  <= (ecnt_clr ? sls_pkg::CNT_ZERO : soft_cnt_ff) + 16'(soft_evt);
         frame_cnt_ff <= (ecnt_clr ? sls_pkg::CNT_ZERO : frame_cnt_ff) + 16'(frame_evt);
      end
   end

   // Transmit core.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tx_state_ff <= sls_pkg::st_lane;
         tmr_ff      <= 16'h0000;
         tx_up_ff    <= 1'b0;
         tx_hard_ff  <= 1'b0;
         tx_pd_ff    <= 1'b0;
      end else if (ce) begin
         tx_state_ff <= nxt_tx_state;
         tmr_ff      <= (nxt_tx_state != tx_state_ff) ? 16'h0000 : tmr_ff + 16'h0001;
         tx_up_ff    <= (nxt_tx_state == sls_pkg::st_up);
         tx_hard_ff  <= ~tx_core_rst & (tx_hard_ff | tx_hard_det);
         tx_pd_ff    <= tx_power_down;
      end
   end

   // Receive core.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rx_state_ff   <= sls_pkg::st_lane;
         rx_up_ff      <= 1'b0;
         rx_hard_ff    <= 1'b0;
         rx_pd_ff      <= 1'b0;
         rx_partner_ff <= sls_pkg::PARTNER_RST;
      end else if (ce) begin
         rx_state_ff <= nxt_rx_state;
         rx_up_ff    <= (nxt_rx_state == sls_pkg::st_up);
         rx_hard_ff  <= ~rx_core_rst & (rx_hard_ff | rx_hard_det);
         rx_pd_ff    <= rx_power_down;
         rx_partner_ff.aligned  <= (nxt_rx_state != sls_pkg::st_lane);
         rx_partner_ff.bonded   <= (nxt_rx_state == sls_pkg::st_verify) |
                                   (nxt_rx_state == sls_pkg::st_up);
         rx_partner_ff.verified <= (nxt_rx_state == sls_pkg::st_up);
         // restart request, driven in every mode
         rx_partner_ff.restart  <= rx_need_restart | rx_core_rst;
      end
   end

   // Receive data and error pulses.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         frame_q_ff   <= 1'b0;
         soft_q_ff    <= 1'b0;
         frame_err_ff <= 1'b0;
         soft_err_ff  <= 1'b0;
         rx_valid_ff  <= 1'b0;
         rx_data_ff   <= '0;
      end else if (ce) begin
         frame_q_ff   <= rx_frame_det;
         soft_q_ff    <= rx_soft_det;
         frame_err_ff <= frame_evt;
         soft_err_ff  <= soft_evt;
         // data only with lanes and channel up
         rx_valid_ff  <= rx_data_valid_in & rx_all_up & rx_up_ff;
         if (rx_data_valid_in && rx_all_up && rx_up_ff) begin
            rx_data_ff <= rx_data_in;
         end
      end
   end

   // all outputs from user clock flops
   assign prdata           = prdata_ff;
   assign pready           = pready_ff;
   assign pslverr          = pslverr_ff;
   assign tx_gt_power_down = tx_pd_ff;
   assign tx_channel_up    = tx_up_ff;
   assign tx_hard_err      = tx_hard_ff;
   assign rx_gt_power_down = rx_pd_ff;
   assign rx_partner       = rx_partner_ff;
   assign rx_channel_up    = rx_up_ff;
   assign rx_hard_err      = rx_hard_ff;
   assign frame_err        = frame_err_ff;
   assign soft_err         = soft_err_ff;
   assign rx_data_valid    = rx_valid_ff;
   assign rx_data          = rx_data_ff;

endmodule

// ===== sls_status_monitor.sv
// Port-level assertions for the simplex link status block.
`timescale 1ns/100ps
module sls_status_monitor #(
   parameter int LANES  = 4,
   parameter int DATA_W = 32
) (
   input wire logic                  clock,
   input wire logic                  reset_n,
   input wire logic                  psel,
   input wire logic                  pready,
   input wire logic                  pslverr,
   input wire logic                  tx_system_reset,
   input wire logic                  tx_power_down,
   input wire logic                  tx_gt_power_down,
   input wire logic                  tx_channel_up,
   input wire logic [LANES-1:0]      tx_lane_up,
   input wire logic                  tx_hard_err,
   input wire logic                  rx_system_reset,
   input wire logic                  rx_frame_det,
   input wire logic                  rx_soft_det,
   input wire logic                  rx_data_valid_in,
   input wire logic [DATA_W-1:0]     rx_data_in,
   input wire sls_pkg::sls_partner_t rx_partner,
   input wire logic                  rx_channel_up,
   input wire logic [LANES-1:0]      rx_lane_up,
   input wire logic                  frame_err,
   input wire logic                  soft_err,
   input wire logic                  rx_data_valid,
   input wire logic [DATA_W-1:0]     rx_data
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   a_pd_forward: assert property ($past(reset_n) |-> tx_gt_power_down == $past(tx_power_down))
      else $error("power down not forwarded");
   // A software reset write is in flight while psel was high, so those cycles are excused.
   a_hard_sticky: assert property (tx_hard_err && !tx_system_reset && !$past(psel) |=> tx_hard_err)
      else $error("hard error dropped");
   a_frame_once: assert property (frame_err |-> $past(rx_frame_det) && !$past(rx_frame_det, 2))
      else $error("frame error without a fresh cause");
   a_soft_pulse: assert property ($rose(rx_soft_det) |=> soft_err ##1 !soft_err)
      else $error("soft error not a single pulse");
   a_rx_gate: assert property (rx_data_valid |-> $past(rx_data_valid_in) && $past(rx_channel_up)
      && (&$past(rx_lane_up)) && rx_data == $past(rx_data_in)) else $error("ungated rx data");
   a_tx_up_lanes: assert property ($rose(tx_channel_up) |-> &$past(tx_lane_up))
      else $error("tx channel up without lanes");
   a_rx_up_flags: assert property ($rose(rx_channel_up) |-> rx_partner.verified && rx_partner.bonded)
      else $error("rx channel up before bond and verify");
   a_align_lanes: assert property ($rose(rx_partner.aligned) |-> &$past(rx_lane_up))
      else $error("aligned before all lanes up");
   a_restart_req: assert property (rx_system_reset |=> rx_partner.restart)
      else $error("no restart request during rx reset");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");

   c_tx_up: cover property ($rose(tx_channel_up));
   c_rx_up: cover property ($rose(rx_channel_up));
   c_frame: cover property (frame_err);
   c_slverr: cover property (pslverr && pready);
endmodule

bind sls_status_top sls_status_monitor #(.LANES(LANES), .DATA_W(DATA_W)) u_sls_status_monitor (
   .clock(clock), .reset_n(reset_n), .psel(psel), .pready(pready), .pslverr(pslverr),
   .tx_system_reset(tx_system_reset), .tx_power_down(tx_power_down),
   .tx_gt_power_down(tx_gt_power_down), .tx_channel_up(tx_channel_up),
   .tx_lane_up(tx_lane_up), .tx_hard_err(tx_hard_err), .rx_system_reset(rx_system_reset),
   .rx_frame_det(rx_frame_det), .rx_soft_det(rx_soft_det), .rx_data_valid_in(rx_data_valid_in),
   .rx_data_in(rx_data_in), .rx_partner(rx_partner), .rx_channel_up(rx_channel_up),
   .rx_lane_up(rx_lane_up), .frame_err(frame_err), .soft_err(soft_err),
   .rx_data_valid(rx_data_valid), .rx_data(rx_data)
);

// ===== sls_partner_model.sv
// Relay of receive-side progress flags into the transmit core, prompt or lagging.
`timescale 1ns/100ps
module sls_partner_model (
   input  wire logic                  clock,
   input  wire logic                  reset_n,
   input  wire logic                  slow,
   input  wire sls_pkg::sls_partner_t from_rx,
   output sls_pkg::sls_partner_t      to_tx
);
   sls_pkg::sls_partner_t dly_ff [3];

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         dly_ff <= '{default: sls_pkg::PARTNER_RST};
      end else begin
         dly_ff <= '{from_rx, dly_ff[0], dly_ff[1]};
      end
   end

   assign to_tx = slow ? dly_ff[2] : from_rx;
endmodule

// ===== sls_status_top_bench.sv
// Randomised bench for the simplex link status block with its partner relay.
`timescale 1ns/100ps
module sls_status_top_bench;
   logic                  clock = 1'b0, reset_n = 1'b0, ce = 1'b1, slow = 1'b0;
   logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]           paddr = 12'h000;
   logic [31:0]           pwdata = 32'h0, rx_data_in = 32'h0, prdata, rx_data;
   logic                  tx_system_reset = 1'b1, rx_system_reset = 1'b1;
   logic                  tx_hard_det = 1'b0, rx_hard_det = 1'b0;
   logic                  tx_power_down = 1'b0, rx_power_down = 1'b0;
   logic                  rx_bond_done = 1'b0, rx_verify_done = 1'b0;
   logic                  rx_frame_det = 1'b0, rx_soft_det = 1'b0, rx_data_valid_in = 1'b0;
   logic [3:0]            tx_lane_ok = 4'h0, rx_lane_sync = 4'h0, tx_lane_up, rx_lane_up;
   logic                  pready, pslverr, tx_gt_power_down, tx_channel_up, tx_hard_err;
   logic                  rx_gt_power_down, rx_channel_up, rx_hard_err;
   logic                  frame_err, soft_err, rx_data_valid;
   sls_pkg::sls_partner_t tx_partner, rx_partner;
   int                    error_cnt = 0, n_checks = 0;

   always #4 clock = ~clock;

   sls_partner_model u_sls_partner_model (.clock(clock), .reset_n(reset_n), .slow(slow),
      .from_rx(rx_partner), .to_tx(tx_partner));

   sls_status_top #(.LANES(4), .DATA_W(32), .LOCK_CYC(2), .TIMER_CYC(4)) u_sls_status_top (
      .clock(clock), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_system_reset(tx_system_reset), .tx_partner(tx_partner),
      .tx_lane_ok(tx_lane_ok), .tx_hard_det(tx_hard_det), .tx_power_down(tx_power_down),
      .tx_gt_power_down(tx_gt_power_down), .tx_channel_up(tx_channel_up),
      .tx_lane_up(tx_lane_up), .tx_hard_err(tx_hard_err), .rx_system_reset(rx_system_reset),
      .rx_lane_sync(rx_lane_sync), .rx_bond_done(rx_bond_done),
      .rx_verify_done(rx_verify_done), .rx_frame_det(rx_frame_det), .rx_soft_det(rx_soft_det),
      .rx_hard_det(rx_hard_det), .rx_power_down(rx_power_down),
      .rx_data_valid_in(rx_data_valid_in), .rx_data_in(rx_data_in),
      .rx_gt_power_down(rx_gt_power_down), .rx_partner(rx_partner),
      .rx_channel_up(rx_channel_up), .rx_lane_up(rx_lane_up), .rx_hard_err(rx_hard_err),
      .frame_err(frame_err), .soft_err(soft_err), .rx_data_valid(rx_data_valid),
      .rx_data(rx_data));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic end_of_test();
      if (error_cnt == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic hang();
      error_cnt++;
      end_of_test();
   endtask

   // Starts one edge late so a back-to-back call never re-drives psel in the same step.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv, output logic err);
      int n;
      n = 0;
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= wd;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20)
         hang();
      rdv = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_lvl(ref logic sig, input logic lvl);
      int n;
      n = 0;
      while (sig !== lvl && n < 300) begin
         @(posedge clock);
         n++;
      end
      if (n >= 300)
         hang();
   endtask

   function automatic logic [31:0] exp_status(input logic up, input logic [3:0] ln);
      return {8'h00, 4'h0, ln, 4'h0, ln, 1'b0, {3{up}}, 1'b0, up, 1'b0, up};
   endfunction

   // Random data and power-down; outputs lag the inputs by one register.
   task automatic data_run(input logic up);
      logic        vin [24];
      logic        pdv [24];
      logic [31:0] din [24];
      for (int i = 0; i < 24; i++) begin
         vin[i] = 1'($urandom);
         pdv[i] = 1'($urandom);
         din[i] = $urandom;
         rx_data_valid_in <= vin[i];
         rx_data_in       <= din[i];
         rx_power_down    <= pdv[i];
         tx_power_down    <= pdv[i];
         @(posedge clock);
         if (i > 0) begin
            check("rx valid", 32'(rx_data_valid), 32'(vin[i-1] & up));
            check("rx pd", 32'(rx_gt_power_down), 32'(pdv[i-1]));
            if (vin[i-1] & up)
               check("rx data", rx_data, din[i-1]);
         end
      end
      rx_data_valid_in <= 1'b0;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      hang();
   end

   initial begin
      logic [31:0] rd;
      logic        err;
      int          nf, ns;
      logic        f, s;
      nf = $urandom(3322);
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      repeat (3) @(posedge clock);
      tx_system_reset <= 1'b0;
      rx_system_reset <= 1'b0;
      apb(1'b0, sls_pkg::STAT_OFS, 32'h0, rd, err);
      check("idle status", rd, exp_status(1'b0, 4'h0));
      apb(1'b1, sls_pkg::CTRL_OFS, 32'h0000_0007, rd, err);
      apb(1'b0, sls_pkg::CTRL_OFS, 32'h0, rd, err);
      check("ctrl", rd, 32'h0000_0001);
      apb(1'b1, sls_pkg::CTRL_OFS, 32'h0, rd, err);
      apb(1'b0, 12'h00c, 32'h0, rd, err);
      check("unmapped err", 32'(err), 32'h0000_0001);
      check("unmapped data", rd, 32'h0);
      data_run(1'b0);
      rx_lane_sync   <= 4'hf;
      tx_lane_ok     <= 4'hf;
      rx_bond_done   <= 1'b1;
      rx_verify_done <= 1'b1;
      wait_lvl(rx_channel_up, 1'b1);
      wait_lvl(tx_channel_up, 1'b1);
      apb(1'b0, sls_pkg::STAT_OFS, 32'h0, rd, err);
      check("up status", rd, exp_status(1'b1, 4'hf));
      data_run(1'b1);
      apb(1'b1, sls_pkg::ECNT_OFS, 32'h0, rd, err);
      nf = 0;
      ns = 0;
      for (int i = 0; i < 8; i++) begin
         f = 1'($urandom);
         s = 1'($urandom);
         nf += int'(f);
         ns += int'(s);
         rx_frame_det <= f;
         rx_soft_det  <= s;
         repeat (1 + $urandom % 3) @(posedge clock);
         rx_frame_det <= 1'b0;
         rx_soft_det  <= 1'b0;
         repeat (2) @(posedge clock);
      end
      apb(1'b0, sls_pkg::ECNT_OFS, 32'h0, rd, err);
      check("error counts", rd, {16'(nf), 16'(ns)});
      // lane loss restarts the transmitter, which then waits for verify
      slow           <= 1'b1;
      rx_verify_done <= 1'b0;
      rx_lane_sync   <= 4'h7;
      wait_lvl(rx_channel_up, 1'b0);
      wait_lvl(tx_channel_up, 1'b0);
      rx_lane_sync <= 4'hf;
      repeat (40) @(posedge clock);
      check("tx waits verify", 32'(tx_channel_up), 32'h0);
      check("rx waits verify", 32'(rx_channel_up), 32'h0);
      // timer mode: transmitter stops waiting, receiver still reports progress
      apb(1'b1, sls_pkg::CTRL_OFS, 32'h0000_0001, rd, err);
      wait_lvl(tx_channel_up, 1'b1);
      check("timer rx up", 32'(rx_channel_up), 32'h0);
      check("timer aligned", 32'(rx_partner.aligned), 32'h1);
      check("timer bonded", 32'(rx_partner.bonded), 32'h1);
      apb(1'b1, sls_pkg::CTRL_OFS, 32'h0, rd, err);
      rx_verify_done <= 1'b1;
      wait_lvl(rx_channel_up, 1'b1);
      wait_lvl(tx_channel_up, 1'b1);
      tx_hard_det <= 1'b1;
      rx_hard_det <= 1'b1;
      @(posedge clock);
      tx_hard_det <= 1'b0;
      rx_hard_det <= 1'b0;
      wait_lvl(tx_hard_err, 1'b1);
      wait_lvl(rx_hard_err, 1'b1);
      repeat (20) @(posedge clock);
      check("tx hard held", 32'(tx_hard_err), 32'h1);
      check("rx hard held", 32'(rx_hard_err), 32'h1);
      tx_system_reset <= 1'b1;
      rx_system_reset <= 1'b1;
      repeat (6) @(posedge clock);
      tx_system_reset <= 1'b0;
      rx_system_reset <= 1'b0;
      repeat (2) @(posedge clock);
      check("tx hard cleared", 32'(tx_hard_err), 32'h0);
      check("rx hard cleared", 32'(rx_hard_err), 32'h0);
      end_of_test();
   end
endmodule
